/* File: verilog/complex_interrupt_distributor.sv */
`timescale 1ns/1ps
// How it works
// - One complex-wide interrupt-on flag; while clear, all timesharing interrupts wait pending.
// - Disable operation clears the flag and returns its prior value atomically.
// - Subcomplex variant adds a realtime flag; CPU mode picks which flag acts.
// - Per-CPU and complex 8-bit enable masks; bit n gates channel n.
// - Set bit enables, clear bit masks; separate operations write each mask.
// - Subcomplex masks are 16 bits written whole; high byte is realtime.
// - Realtime numbers 0x100-0x102 map to bits 2-4, 0xf9-0xfd to 5-9.
// - Subcomplex uses timesharing bits for timesharing CPUs, realtime bits otherwise.
// - 3-bit target CPU register; all ones means any CPU may take it.
// - 8-bit delivery mode: clear bit single CPU, set bit all CPUs.
// - Control word holds service set index, 3 bits basic, 5 bits otherwise.
// - Later variants: eight broadcast masks; nonzero mask broadcasts to marked CPUs.
// - Four-CPU variant uses only bits 3..0 of each broadcast mask.
// - Broadcast masks read and written by channel-indexed move operations.
// - Interrupts enter by setting their channel bit in the global pending register.
// - Pending bit proceeds only with flag set and complex enable bit set.
// - Basic single-CPU: target 0-3 delivers only there, if locally enabled.
// - Target all ones picks an enabled idle CPU; all idle gives the lowest enabled CPU.
// - Acceptance sets local pending bits, clears global bit and the flag.
// - Checks repeat every clock; unplaceable pending bits stay set.
// - Later single-CPU: lowest enabled idle CPU, else lowest enabled active CPU.
// - Later broadcast only when every marked CPU has the channel enabled.
module complex_interrupt_distributor #(
  parameter irq_dist_pkg::variant_t VARIANT = irq_dist_pkg::VAR_LATER
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Interrupt sources
  input wire logic [irq_dist_pkg::NUM_CHAN-1:0] ts_raise,
  input wire logic rt_raise_valid,
  input wire logic [8:0] rt_raise_number,
  // CPU status
  input wire irq_dist_pkg::cpu_vec_t cpu_idle,
  input wire irq_dist_pkg::cpu_vec_t cpu_realtime_mode,
  // Local pending acknowledge
  input wire logic ack_valid,
  input wire logic [irq_dist_pkg::CPU_W-1:0] ack_cpu,
  input wire logic [3:0] ack_channel,
  // Operation port
  input wire irq_dist_pkg::op_req_t op_req,
  output irq_dist_pkg::op_rsp_t op_rsp,
  // State
  output logic complex_irq_on_flag,
  output logic realtime_irq_on_flag,
  output irq_dist_pkg::chan_vec_t global_pending,
  output irq_dist_pkg::chan_vec_t [irq_dist_pkg::NUM_CPUS-1:0] local_pending,
  output logic [irq_dist_pkg::INDEX_W-1:0] service_comm_set_index,
  output logic accept_pulse,
  output logic [3:0] accept_channel
);
  import irq_dist_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic irq_on, rt_irq_on, next_irq_on, next_rt_irq_on;
  chan_vec_t gmask, next_gmask, gpend, next_gpend;
  chan_vec_t [NUM_CPUS-1:0] lmask, next_lmask, lpend, next_lpend;
  logic [CPU_W-1:0] target, next_target;
  logic [NUM_CHAN-1:0] mode, next_mode;
  logic [INDEX_W-1:0] index, next_index;
  cpu_vec_t [NUM_CHAN-1:0] bcast, next_bcast;
  op_rsp_t rsp, next_rsp;
  logic acc_q, next_acc_q;
  logic [3:0] acc_ch_q, next_acc_ch_q;

  // ----------------------------------------
  // Variant shaping
  // ----------------------------------------
  cpu_vec_t present;
  chan_vec_t mask_width;
  logic [INDEX_W-1:0] index_width;
  assign present = (VARIANT == VAR_BASIC || VARIANT == VAR_FOUR_CPU) ? CPUS_FOUR : CPUS_ALL;
  assign mask_width = (VARIANT == VAR_SUBCOMPLEX) ? MASK_WIDE : MASK_NARROW;
  assign index_width = (VARIANT == VAR_BASIC) ? INDEX_MASK_BASIC : INDEX_MASK_WIDE;

  // ----------------------------------------
  // Destination checks per channel
  // ----------------------------------------
  chan_vec_t eligible, acc_onehot;
  cpu_vec_t [MASK_W-1:0] route_dest;

  for (genvar c = 0; c < MASK_W; c++)
  begin : g_chan
    localparam bit IS_RT = (c >= RT_BASE);
    localparam int SLOT = c % NUM_CHAN;
    cpu_vec_t en_cpus, idle_grant, act_grant, bc_targets, dest;
    logic is_bc, flag_on, elig;

    lowest_pick #(.W(NUM_CPUS)) u_idle (
      .req(en_cpus & cpu_idle),
      .grant(idle_grant),
      .any()
    );
    lowest_pick #(.W(NUM_CPUS)) u_active (
      .req(en_cpus),
      .grant(act_grant),
      .any()
    );

    always_comb
    begin
      for (int i = 0; i < NUM_CPUS; i++)
      begin
        en_cpus[i] = lmask[i][c] & present[i] &
          ((VARIANT == VAR_SUBCOMPLEX) ? (cpu_realtime_mode[i] == IS_RT) : !IS_RT);
      end
      bc_targets = (VARIANT == VAR_BASIC) ? present : (bcast[SLOT] & present);
      is_bc = (VARIANT == VAR_BASIC) ? mode[SLOT] : |bc_targets;
      if (is_bc)
      begin
        dest = ((bc_targets & ~en_cpus) == '0) ? bc_targets : '0;
      end
      else if (VARIANT == VAR_BASIC)
      begin
        dest = (target != TARGET_ANY) ? en_cpus & (cpu_vec_t'(1) << target) : idle_grant;
      end
      else
      begin
        dest = (idle_grant != '0) ? idle_grant : act_grant;
      end
      flag_on = IS_RT ? rt_irq_on : irq_on;
      elig = gpend[c] & flag_on & gmask[c] & (dest != '0);
    end

    assign route_dest[c] = dest;
    assign eligible[c] = elig;
  end

  // Only one acceptance per clock, since only the lowest eligible channel is granted
  lowest_pick #(.W(MASK_W)) u_chan (
    .req(eligible),
    .grant(acc_onehot),
    .any()
  );

  logic accept_fire;
  logic [3:0] acc_chan;
  cpu_vec_t acc_dest, chan_col;
  always_comb
  begin
    accept_fire = |acc_onehot;
    acc_chan = 4'h0;
    for (int i = 0; i < MASK_W; i++)
    begin
      if (acc_onehot[i])
      begin
        acc_chan = 4'(i);
      end
    end
    acc_dest = route_dest[acc_chan];
    for (int i = 0; i < NUM_CPUS; i++)
    begin
      chan_col[i] = lpend[i][acc_ch_q];
    end
  end

  // ----------------------------------------
  // Raise decode
  // ----------------------------------------
  logic [4:0] rt_map;
  chan_vec_t raise_vec;
  always_comb
  begin
    rt_map = rt_enable_bit(rt_raise_number);
    raise_vec = {8'h00, ts_raise};
    if (VARIANT == VAR_SUBCOMPLEX && rt_raise_valid && rt_map[4])
    begin
      raise_vec[4'(RT_BASE) + rt_map[3:0] - RT_LOW_BIT] = 1'b1;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic op_rt;
  always_comb
  begin
    next_irq_on = irq_on;
    next_rt_irq_on = rt_irq_on;
    next_gmask = gmask;
    next_lmask = lmask;
    next_target = target;
    next_mode = mode;
    next_index = index;
    next_bcast = bcast;
    next_lpend = lpend;
    next_rsp = '0;
    op_rt = (VARIANT == VAR_SUBCOMPLEX) && cpu_realtime_mode[op_req.cpu];
    if (op_req.valid)
    begin
      next_rsp.valid = (op_req.code != OP_NONE);
      case (op_req.code)
        OP_ENABLE_IRQ:
        begin
          next_rt_irq_on = op_rt ? 1'b1 : rt_irq_on;
          next_irq_on = op_rt ? irq_on : 1'b1;
        end
        OP_DISABLE_IRQ:
        begin
          next_rsp.data = {15'h0000, op_rt ? rt_irq_on : irq_on};
          next_rt_irq_on = op_rt ? 1'b0 : rt_irq_on;
          next_irq_on = op_rt ? irq_on : 1'b0;
        end
        OP_WIDE_CPU_MASK_UPDATE: next_lmask[op_req.cpu] = op_req.data & mask_width;
        OP_WIDE_COMPLEX_MASK_UPDATE: next_gmask = op_req.data & mask_width;
        OP_WRITE_TARGET: next_target = op_req.data[CPU_W-1:0];
        OP_WRITE_CONTROL:
        begin
          next_mode = op_req.data[CTRL_MODE_LSB +: NUM_CHAN];
          next_index = op_req.data[CTRL_INDEX_LSB +: INDEX_W] & index_width;
        end
        OP_WRITE_BCAST: next_bcast[op_req.index] = op_req.data[NUM_CPUS-1:0] & present;
        OP_READ_BCAST: next_rsp.data = {8'h00, bcast[op_req.index]};
        OP_READ_CPU_MASK: next_rsp.data = lmask[op_req.cpu];
        OP_READ_COMPLEX_MASK: next_rsp.data = gmask;
        OP_READ_CONTROL: next_rsp.data = {3'h0, index, mode};
        OP_READ_TARGET: next_rsp.data = {13'h0000, target};
        OP_READ_LOCAL_PENDING: next_rsp.data = lpend[op_req.cpu];
        default: next_rsp.data = '0;
      endcase
    end
    if (ack_valid)
    begin
      next_lpend[ack_cpu][ack_channel] = 1'b0;
    end
    // Hardware acceptance outranks a same-cycle enable
    if (accept_fire)
    begin
      for (int i = 0; i < NUM_CPUS; i++)
      begin
        if (acc_dest[i])
        begin
          next_lpend[i][acc_chan] = 1'b1;
        end
      end
      next_rt_irq_on = (acc_chan >= 4'(RT_BASE)) ? 1'b0 : next_rt_irq_on;
      next_irq_on = (acc_chan >= 4'(RT_BASE)) ? next_irq_on : 1'b0;
    end
    next_gpend = (gpend & ~acc_onehot) | raise_vec;
    next_acc_q = accept_fire;
    next_acc_ch_q = acc_chan;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq_on <= 1'b0;
      rt_irq_on <= 1'b0;
      gmask <= RESET_MASK;
      lmask <= '0;
      gpend <= RESET_MASK;
      lpend <= '0;
      target <= RESET_TARGET;
      mode <= '0;
      index <= '0;
      bcast <= '0;
      rsp <= '0;
      acc_q <= 1'b0;
      acc_ch_q <= 4'h0;
    end
    else
    begin
      irq_on <= next_irq_on;
      rt_irq_on <= next_rt_irq_on;
      gmask <= next_gmask;
      lmask <= next_lmask;
      gpend <= next_gpend;
      lpend <= next_lpend;
      target <= next_target;
      mode <= next_mode;
      index <= next_index;
      bcast <= next_bcast;
      rsp <= next_rsp;
      acc_q <= next_acc_q;
      acc_ch_q <= next_acc_ch_q;
    end
  end

  assign op_rsp = rsp;
  assign complex_irq_on_flag = irq_on;
  assign realtime_irq_on_flag = rt_irq_on;
  assign global_pending = gpend;
  assign local_pending = lpend;
  assign service_comm_set_index = index;
  assign accept_pulse = acc_q;
  assign accept_channel = acc_ch_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_ACCEPT_DROPS_FLAG: assert property (accept_fire && acc_chan < 4'(RT_BASE) |=> !irq_on)
    else $error("flag still set after acceptance");
  AST_NO_ACCEPT_FLAG_OFF: assert property (accept_fire |-> (acc_chan >= 4'(RT_BASE) ? rt_irq_on : irq_on))
    else $error("acceptance while interrupts off");
  AST_COMPLEX_ENABLE: assert property (accept_fire |-> gmask[acc_chan])
    else $error("acceptance of complex-masked channel");
  AST_DISABLE_PRIOR: assert property (op_req.valid && op_req.code == OP_DISABLE_IRQ && !op_rt
    |=> rsp.valid && rsp.data[0] == $past(irq_on) && !irq_on)
    else $error("disable did not return prior flag");
  AST_LOCAL_SET: assert property (accept_fire |=> ($past(acc_dest) & ~chan_col) == '0)
    else $error("local pending not set");
  AST_GLOBAL_HELD: assert property (1'b1 |=> ($past(gpend) & ~$past(acc_onehot) & ~gpend) == '0)
    else $error("pending bit lost without acceptance");
  AST_LOWEST_FIRST: assert property (accept_fire
    |-> (eligible & ((chan_vec_t'(1) << acc_chan) - 16'h0001)) == '0)
    else $error("higher channel accepted first");
  AST_BASIC_TARGET: assert property (VARIANT == VAR_BASIC && accept_fire && !mode[acc_chan[2:0]]
    && target != TARGET_ANY |-> acc_dest == (cpu_vec_t'(1) << target))
    else $error("fixed target not honoured");
  AST_BCAST_ENABLED: assert property (VARIANT != VAR_BASIC && accept_fire && bcast[acc_chan[2:0]] != '0
    |-> acc_dest == (bcast[acc_chan[2:0]] & present))
    else $error("broadcast to unready CPUs");
  AST_PRESENT_ONLY: assert property (accept_fire |-> (acc_dest & ~present) == '0)
    else $error("delivery to absent CPU");
  AST_RESET_CLEAR: assert property ($fell(rst) |-> !irq_on && gpend == '0 && gmask == '0)
    else $error("state not cleared by reset");

  COV_SINGLE: cover property (accept_fire && $countones(acc_dest) == 1);
  COV_BCAST: cover property (accept_fire && $countones(acc_dest) > 1);
  COV_HELD: cover property (gpend != '0 && !irq_on [*3]);
endmodule

/* File: verilog/irq_dist_pkg.sv */
package irq_dist_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CPUS = 8;
  localparam int CPU_W = 3;
  localparam int NUM_CHAN = 8;
  localparam int MASK_W = 16;
  localparam int RT_BASE = 8;
  localparam int INDEX_W = 5;

  // ----------------------------------------
  // Values and field positions
  // ----------------------------------------
  localparam logic [CPU_W-1:0] TARGET_ANY = 3'h7;
  localparam logic [NUM_CPUS-1:0] CPUS_ALL = 8'hff;
  localparam logic [NUM_CPUS-1:0] CPUS_FOUR = 8'h0f;
  localparam logic [MASK_W-1:0] MASK_NARROW = 16'h00ff;
  localparam logic [MASK_W-1:0] MASK_WIDE = 16'hffff;
  localparam logic [INDEX_W-1:0] INDEX_MASK_BASIC = 5'h07;
  localparam logic [INDEX_W-1:0] INDEX_MASK_WIDE = 5'h1f;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INDEX_LSB = 8;
  localparam logic [MASK_W-1:0] RESET_MASK = 16'h0000;
  localparam logic [CPU_W-1:0] RESET_TARGET = 3'h0;

  // ----------------------------------------
  // Realtime channel numbers to enable bits
  // ----------------------------------------
  localparam logic [8:0] RT_NUM_LOW_FIRST = 9'h100;
  localparam logic [8:0] RT_NUM_LOW_LAST = 9'h102;
  localparam logic [8:0] RT_NUM_HIGH_FIRST = 9'h0f9;
  localparam logic [8:0] RT_NUM_HIGH_LAST = 9'h0fd;
  localparam logic [3:0] RT_LOW_BIT = 4'h2;
  localparam logic [3:0] RT_HIGH_BIT = 4'h5;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [NUM_CPUS-1:0] cpu_vec_t;
  typedef logic [MASK_W-1:0] chan_vec_t;

  typedef enum logic [1:0] {VAR_BASIC, VAR_LATER, VAR_FOUR_CPU, VAR_SUBCOMPLEX} variant_t;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_ENABLE_IRQ,
    OP_DISABLE_IRQ,
    OP_WIDE_CPU_MASK_UPDATE,
    OP_WIDE_COMPLEX_MASK_UPDATE,
    OP_WRITE_TARGET,
    OP_WRITE_CONTROL,
    OP_WRITE_BCAST,
    OP_READ_BCAST,
    OP_READ_CPU_MASK,
    OP_READ_COMPLEX_MASK,
    OP_READ_CONTROL,
    OP_READ_TARGET,
    OP_READ_LOCAL_PENDING
  } op_code_t;

  typedef struct packed {
    logic valid;
    op_code_t code;
    logic [CPU_W-1:0] cpu;
    logic [CPU_W-1:0] index;
    logic [MASK_W-1:0] data;
  } op_req_t;

  typedef struct packed {
    logic valid;
    logic [MASK_W-1:0] data;
  } op_rsp_t;

  // Result: {hit, enable bit index}
  function automatic logic [4:0] rt_enable_bit(input logic [8:0] num);
    logic [4:0] res;
    res = 5'h00;
    if (num >= RT_NUM_LOW_FIRST && num <= RT_NUM_LOW_LAST)
    begin
      res = {1'b1, 4'(num - RT_NUM_LOW_FIRST) + RT_LOW_BIT};
    end
    else if (num >= RT_NUM_HIGH_FIRST && num <= RT_NUM_HIGH_LAST)
    begin
      res = {1'b1, 4'(num - RT_NUM_HIGH_FIRST) + RT_HIGH_BIT};
    end
    return res;
  endfunction

endpackage

/* File: verilog/lowest_pick.sv */
`timescale 1ns/1ps
module lowest_pick #(
  parameter int W = 8
) (
  // Request and one-hot grant
  input wire logic [W-1:0] req,
  output logic [W-1:0] grant,
  output logic any
);
  // Two's complement trick isolates the lowest set bit
  assign grant = req & (~req + W'(1));
  assign any = |req;
endmodule

/* File: dv/cpu_io_model.sv */
`timescale 1ns/1ps
module cpu_io_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bench commands
  input wire logic [7:0] raise_cmd,
  input wire irq_dist_pkg::cpu_vec_t idle_cmd,
  input wire logic ack_cmd,
  input wire logic [2:0] ack_cpu_cmd,
  input wire logic [3:0] ack_chan_cmd,
  // Toward the distributor
  output logic [7:0] ts_raise,
  output irq_dist_pkg::cpu_vec_t cpu_idle,
  output logic ack_valid,
  output logic [2:0] ack_cpu,
  output logic [3:0] ack_channel
);
  import irq_dist_pkg::*;

  // ----------------------------------------
  // Devices and CPUs
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    // One-cycle raise pulse per channel
    ts_raise <= rst ? 8'h00 : raise_cmd;
    cpu_idle <= idle_cmd;
    // Ack only once the handler is entered
    ack_valid <= rst ? 1'b0 : ack_cmd;
    // Released lines toggle, so stale values never look valid
    ack_cpu <= ack_cmd ? ack_cpu_cmd : ~ack_cpu;
    ack_channel <= ack_cmd ? ack_chan_cmd : ~ack_channel;
  end
endmodule

/* File: dv/test_complex_interrupt_distributor.sv */
`timescale 1ns/1ps
module test_complex_interrupt_distributor;
  import irq_dist_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk, rst, ack_cmd, ack_valid, flag, rt_flag, apulse;
  logic [7:0] raise_cmd, ts_raise;
  cpu_vec_t idle_cmd, cpu_idle;
  logic [2:0] ack_cpu_cmd, ack_cpu;
  logic [3:0] ack_chan_cmd, ack_channel, achan;
  op_req_t op_req;
  op_rsp_t op_rsp;
  chan_vec_t gp;
  chan_vec_t [NUM_CPUS-1:0] lp;
  logic [INDEX_W-1:0] idx;
  logic [15:0] rd;
  int miscompares, cmp_count;

  cpu_io_model partner (.ref_clk(ref_clk), .rst(rst), .raise_cmd(raise_cmd), .idle_cmd(idle_cmd),
    .ack_cmd(ack_cmd), .ack_cpu_cmd(ack_cpu_cmd), .ack_chan_cmd(ack_chan_cmd), .ts_raise(ts_raise),
    .cpu_idle(cpu_idle), .ack_valid(ack_valid), .ack_cpu(ack_cpu), .ack_channel(ack_channel));

  complex_interrupt_distributor #(.VARIANT(VAR_LATER)) dut (.ref_clk(ref_clk), .rst(rst),
    .ts_raise(ts_raise), .rt_raise_valid(1'b0), .rt_raise_number(9'h000), .cpu_idle(cpu_idle),
    .cpu_realtime_mode(8'h00), .ack_valid(ack_valid), .ack_cpu(ack_cpu), .ack_channel(ack_channel),
    .op_req(op_req), .op_rsp(op_rsp), .complex_irq_on_flag(flag), .realtime_irq_on_flag(rt_flag),
    .global_pending(gp), .local_pending(lp), .service_comm_set_index(idx), .accept_pulse(apulse),
    .accept_channel(achan));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask

  // Request held one edge; answer is read right after it
  task automatic op(input op_code_t c, input logic [2:0] cpu, input logic [2:0] ix, input logic [15:0] d);
    @(posedge ref_clk);
    op_req <= '{1'b1, c, cpu, ix, d};
    @(posedge ref_clk);
    op_req.valid <= 1'b0;
    #1;
    rd = op_rsp.data;
  endtask

  task automatic lmask(input logic [2:0] cpu, input logic [15:0] v);
    op(OP_WIDE_CPU_MASK_UPDATE, cpu, 3'h0, v);
  endtask

  task automatic enable_irq;
    op(OP_ENABLE_IRQ, 3'h0, 3'h0, 16'h0000);
  endtask

  task automatic raise(input logic [7:0] b);
    @(posedge ref_clk);
    raise_cmd <= b;
    @(posedge ref_clk);
    raise_cmd <= 8'h00;
    step;
  endtask

  task automatic idle(input cpu_vec_t v);
    @(posedge ref_clk);
    idle_cmd <= v;
    step;
    step;
  endtask

  task automatic ack(input logic [2:0] cpu, input logic [3:0] ch);
    @(posedge ref_clk);
    ack_cmd <= 1'b1;
    ack_cpu_cmd <= cpu;
    ack_chan_cmd <= ch;
    @(posedge ref_clk);
    ack_cmd <= 1'b0;
    step;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check("flag", 16'h0000, flag);
    check("realtime flag", 16'h0000, rt_flag);
    check("global pending", 16'h0000, gp);
    op(OP_READ_CPU_MASK, 3'h3, 3'h0, 16'h0000);
    check("cpu mask", 16'h0000, rd);
    check("answer valid", 16'h0001, op_rsp.valid);
    op(OP_WRITE_CONTROL, 3'h0, 3'h0, 16'h1fa5);
    check("comm set index", 16'h001f, idx);
    op(OP_READ_CONTROL, 3'h0, 3'h0, 16'h0000);
    check("control word", 16'h1fa5, rd);
    op(OP_WRITE_TARGET, 3'h0, 3'h0, 16'hffff);
    op(OP_READ_TARGET, 3'h0, 3'h0, 16'h0000);
    check("target cpu", 16'h0007, rd);
    op(OP_WIDE_COMPLEX_MASK_UPDATE, 3'h0, 3'h0, 16'hfffb);
    op(OP_READ_COMPLEX_MASK, 3'h0, 3'h0, 16'h0000);
    check("complex mask", 16'h00fb, rd);
  endtask

  task automatic t_walk;
    lmask(3'h1, 16'h0001);
    raise(8'h01);
    step;
    check("held pending", 16'h0001, gp);
    check("no local", 16'h0000, lp[1]);
    enable_irq;
    check("flag on", 16'h0001, flag);
    check("realtime flag idle", 16'h0000, rt_flag);
    step;
    check("pending cleared", 16'h0000, gp);
    check("local set", 16'h0001, lp[1]);
    check("flag off", 16'h0000, flag);
    check("accept pulse", 16'h0001, apulse);
    check("accept channel", 16'h0000, achan);
    op(OP_READ_LOCAL_PENDING, 3'h1, 3'h0, 16'h0000);
    check("local pending read", 16'h0001, rd);
    ack(3'h1, 4'h0);
    check("local acked", 16'h0000, lp[1]);
  endtask

  task automatic t_disable;
    enable_irq;
    op(OP_DISABLE_IRQ, 3'h0, 3'h0, 16'h0000);
    check("prior on", 16'h0001, rd[0]);
    check("flag cleared", 16'h0000, flag);
    op(OP_DISABLE_IRQ, 3'h0, 3'h0, 16'h0000);
    check("prior off", 16'h0000, rd[0]);
  endtask

  task automatic t_gmask;
    lmask(3'h0, 16'h0004);
    enable_irq;
    raise(8'h04);
    step;
    check("masked pending", 16'h0004, gp);
    check("flag kept", 16'h0001, flag);
    op(OP_DISABLE_IRQ, 3'h0, 3'h0, 16'h0000);
    op(OP_WIDE_COMPLEX_MASK_UPDATE, 3'h0, 3'h0, 16'h00ff);
    enable_irq;
    step;
    check("unmasked local", 16'h0004, lp[0]);
    ack(3'h0, 4'h2);
  endtask

  task automatic t_pick;
    lmask(3'h2, 16'h0008);
    lmask(3'h5, 16'h0008);
    lmask(3'h6, 16'h0008);
    idle(8'h60);
    raise(8'h08);
    enable_irq;
    step;
    check("idle pick", 16'h0008, lp[5]);
    check("active skipped", 16'h0000, lp[2]);
    check("higher idle", 16'h0000, lp[6]);
    ack(3'h5, 4'h3);
    idle(8'h00);
    raise(8'h08);
    enable_irq;
    step;
    check("active pick", 16'h0008, lp[2]);
    check("no idle pick", 16'h0000, lp[5]);
    ack(3'h2, 4'h3);
  endtask

  task automatic t_bcast;
    op(OP_WRITE_BCAST, 3'h0, 3'h4, 16'h0006);
    op(OP_READ_BCAST, 3'h0, 3'h4, 16'h0000);
    check("bcast mask", 16'h0006, rd);
    lmask(3'h1, 16'h0011);
    raise(8'h10);
    enable_irq;
    step;
    step;
    check("bcast held", 16'h0010, gp);
    op(OP_DISABLE_IRQ, 3'h0, 3'h0, 16'h0000);
    lmask(3'h2, 16'h0018);
    enable_irq;
    step;
    check("bcast cpu1", 16'h0010, lp[1]);
    check("bcast cpu2", 16'h0010, lp[2]);
    check("unmarked cpu0", 16'h0000, lp[0]);
    ack(3'h1, 4'h4);
    ack(3'h2, 4'h4);
  endtask

  task automatic t_lowest;
    lmask(3'h3, 16'h0060);
    raise(8'h60);
    enable_irq;
    step;
    check("first channel", 16'h0020, lp[3]);
    check("second waits", 16'h0040, gp);
    enable_irq;
    step;
    check("second channel", 16'h0060, lp[3]);
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Whole run is about 130 cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    final_report;
  end

  initial
  begin
    rst = 1'b1;
    raise_cmd = 8'h00;
    idle_cmd = 8'h00;
    ack_cmd = 1'b0;
    ack_cpu_cmd = 3'h0;
    ack_chan_cmd = 4'h0;
    op_req = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    step;
    t_reset;
    t_walk;
    t_disable;
    t_gmask;
    t_pick;
    t_bcast;
    t_lowest;
    final_report;
  end
endmodule
